// >>> logic/cst_defs.vh
// Purpose: Constants for the card setup timing and system wiring registers.
// Assumes: Included by the register block and its bench, by bare name.
// Notes:   Offsets are register indexes, not byte addresses.
//
// How it works
// - Strobe waits S = weight*count+1 clocks.
// - Prescale codes give weights 1,16,256,4096.
// - Bits 5-0 are multiplier 0 to 63.
// - Applies to all four strobes, internal clock.
// - Two setup registers, indexes 3Ah and 3Dh.
// - Timing writes act at once; change when idle.
// - I/O window control bits 3/7 pick set.
// - External data bits 3-0 show sense pins.
// - Byte C bits 52/51 video wiring, reset 0.
// - Byte C bit 50 speaker flag, reset 1.
// - Byte C bit 48 indicator flag, reset 0.
// - Byte D bit 62 external clock flag.
// - Byte B bit 40 is 3.3 V flag.
`ifndef CST_DEFS_VH
`define CST_DEFS_VH

// Ordinary index space.
`define CST_IDX_IO_WIN_CTRL  8'h07
`define CST_IDX_EXT_INDEX    8'h2e
`define CST_IDX_EXT_DATA     8'h2f
`define CST_IDX_SETUP_SET0   8'h3a
`define CST_IDX_SETUP_SET1   8'h3d

// Extended index space.
`define CST_XIDX_VSENSE      8'h0a
`define CST_XIDX_BYTE_B      8'h39
`define CST_XIDX_BYTE_C      8'h3a
`define CST_XIDX_BYTE_D      8'h3b

// Reset values.
`define CST_RST_SETUP        8'h01
`define CST_RST_BYTE_B       8'h53
`define CST_RST_BYTE_C       8'h04
`define CST_RST_BYTE_D       8'h00
`define CST_RST_IO_WIN_CTRL  8'h00

// Field positions.
`define CST_PRESC_HI         7
`define CST_PRESC_LO         6
`define CST_MULT_HI          5
`define CST_MULT_LO          0
`define CST_WIN0_SET_BIT     3
`define CST_WIN1_SET_BIT     7
`define CST_C_VIDEO_B_BIT    4
`define CST_C_VIDEO_A_BIT    3
`define CST_C_SPEAKER_BIT    2
`define CST_C_PER_SKT_BIT    1
`define CST_C_INDICATOR_BIT  0
`define CST_D_EXT_CLK_BIT    6
`define CST_D_LOCK_BIT       1
`define CST_D_CLKRUN_BIT     0
`define CST_B_V33_BIT        0

// Access kinds, one strobe each.
`define CST_KIND_MEM_RD      2'h0
`define CST_KIND_MEM_WR      2'h1
`define CST_KIND_IO_RD       2'h2
`define CST_KIND_IO_WR       2'h3

`endif

// >>> logic/cst_regs.v
// Purpose: Setup timing generator and chip wiring registers.
// Assumes: Single clock; host index port and access requests synchronous.
// Notes:   Command width and recovery are timed elsewhere; acc_end_i ends
//          the strobe.
`timescale 1ns/1ns
`include "cst_defs.vh"

module cst_regs #(
   parameter CNT_W = 18
) (
   // Clock and reset.
   input  wire             mclk_i,
   input  wire             rst_b_i,
   // Host indexed register port.
   input  wire             reg_wr_i,
   input  wire             reg_rd_i,
   input  wire [7:0]       reg_idx_i,
   input  wire [7:0]       reg_wdata_i,
   output reg  [7:0]       reg_rdata_o,
   // Voltage-sense pins.
   input  wire             vs_a_voltage_sense_one_i,
   input  wire             vs_a_voltage_sense_two_i,
   input  wire             vs_b_voltage_sense_one_i,
   input  wire             vs_b_voltage_sense_two_i,
   // Card access request.
   input  wire             acc_start_i,
   input  wire [1:0]       acc_kind_i,
   input  wire             acc_io_win_i,
   input  wire             acc_mem_set_i,
   input  wire             acc_end_i,
   // Card command strobes and status.
   output reg  [3:0]       cmd_strobe_o,
   output reg              acc_busy_o,
   // Wiring flags for the rest of the chip.
   output wire             video_port_a_wired_flag_o,
   output wire             video_port_b_wired_flag_o,
   output wire             speaker_wired_flag_o,
   output wire             status_indicator_wired_flag_o,
   output wire             ext_clock_wired_flag_o,
   output wire             supply_3v3_flag_o
);

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_SETUP = 2'h1;
   localparam [1:0] ST_CMD   = 2'h2;

   reg [7:0]       setup0_ff;
   reg [7:0]       setup1_ff;
   reg [7:0]       io_win_ctrl_ff;
   reg [7:0]       ext_index_ff;
   reg [7:0]       byte_b_ff;
   reg [7:0]       byte_c_ff;
   reg [7:0]       byte_d_ff;
   reg [3:0]       ext_rsvd_ff;
   reg [1:0]       state_ff;
   reg [1:0]       nxt_state;
   reg [CNT_W-1:0] cnt_ff;
   reg [CNT_W-1:0] nxt_cnt;
   reg [1:0]       kind_ff;
   reg [3:0]       nxt_strobe;
   reg             use_set1;
   reg [7:0]       nxt_rdata;
   wire [3:0]      vsense;

   ////////////////////////////////////////////////////////////////////////
   // Setup length S from one timing byte. The widest case, 4096 * 63 + 1,
   // still fits the 18-bit counter.
   function [CNT_W-1:0] setup_len;
      input [7:0] tb;
      reg [CNT_W-1:0] mult;
      begin
         mult = {{(CNT_W-6){1'b0}}, tb[`CST_MULT_HI:`CST_MULT_LO]};
         case (tb[`CST_PRESC_HI:`CST_PRESC_LO])
            2'h0:    setup_len = mult;
            2'h1:    setup_len = mult << 4;
            2'h2:    setup_len = mult << 8;
            default: setup_len = mult << 12;
         endcase
         setup_len = setup_len + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // Bit 0/1 socket A sense one/two, bits 2/3 socket B, live levels.
   assign vsense = {vs_b_voltage_sense_two_i, vs_b_voltage_sense_one_i,
                    vs_a_voltage_sense_two_i, vs_a_voltage_sense_one_i};

   ////////////////////////////////////////////////////////////////////////
   // Register writes. Timing bytes change the next access at once, so
   // software should only touch them while no card access is pending.
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         setup0_ff      <= `CST_RST_SETUP;
         setup1_ff      <= `CST_RST_SETUP;
         io_win_ctrl_ff <= `CST_RST_IO_WIN_CTRL;
         ext_index_ff   <= 8'h00;
         byte_b_ff      <= `CST_RST_BYTE_B;
         byte_c_ff      <= `CST_RST_BYTE_C;
         byte_d_ff      <= `CST_RST_BYTE_D;
         ext_rsvd_ff    <= 4'h0;
      end else if (reg_wr_i) begin
         case (reg_idx_i)
            `CST_IDX_SETUP_SET0:  setup0_ff      <= reg_wdata_i;
            `CST_IDX_SETUP_SET1:  setup1_ff      <= reg_wdata_i;
            `CST_IDX_IO_WIN_CTRL: io_win_ctrl_ff <= reg_wdata_i;
            `CST_IDX_EXT_INDEX:   ext_index_ff   <= reg_wdata_i;
            `CST_IDX_EXT_DATA: begin
               case (ext_index_ff)
                  `CST_XIDX_BYTE_B: byte_b_ff <= reg_wdata_i;
                  `CST_XIDX_BYTE_C: byte_c_ff <= reg_wdata_i;
                  `CST_XIDX_BYTE_D: byte_d_ff <= reg_wdata_i;
                  `CST_XIDX_VSENSE: ext_rsvd_ff <= reg_wdata_i[7:4];
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped indexes read zero. Sense bits ignore writes.
   always @* begin
      nxt_rdata = 8'h00;
      case (reg_idx_i)
         `CST_IDX_SETUP_SET0:  nxt_rdata = setup0_ff;
         `CST_IDX_SETUP_SET1:  nxt_rdata = setup1_ff;
         `CST_IDX_IO_WIN_CTRL: nxt_rdata = io_win_ctrl_ff;
         `CST_IDX_EXT_INDEX:   nxt_rdata = ext_index_ff;
         `CST_IDX_EXT_DATA: begin
            case (ext_index_ff)
               `CST_XIDX_BYTE_B: nxt_rdata = byte_b_ff;
               `CST_XIDX_BYTE_C: nxt_rdata = byte_c_ff;
               `CST_XIDX_BYTE_D: nxt_rdata = byte_d_ff;
               `CST_XIDX_VSENSE: nxt_rdata = {ext_rsvd_ff, vsense};
               default:          nxt_rdata = 8'h00;
            endcase
         end
         default: nxt_rdata = 8'h00;
      endcase
   end

   // Read data is registered: valid the cycle after reg_rd_i.
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         reg_rdata_o <= nxt_rdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Timer set choice: I/O accesses follow the window control bits, memory
   // accesses take the set named by the window logic outside.
   always @* begin
      if (acc_kind_i == `CST_KIND_IO_RD || acc_kind_i == `CST_KIND_IO_WR)
         use_set1 = acc_io_win_i ?
                    io_win_ctrl_ff[`CST_WIN1_SET_BIT] :
                    io_win_ctrl_ff[`CST_WIN0_SET_BIT];
      else
         use_set1 = acc_mem_set_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // Access sequencer: load S on start, count down, then raise the strobe
   // for the requested kind until the access is ended.
   always @* begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_strobe = 4'h0;
      case (state_ff)
         ST_IDLE: begin
            if (acc_start_i) begin
               nxt_cnt   = use_set1 ? setup_len(setup1_ff)
                                    : setup_len(setup0_ff);
               nxt_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
            if (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1}) begin
               nxt_state = ST_CMD;
               nxt_strobe = 4'h1 << kind_ff;
            end
         end
         ST_CMD: begin
            if (acc_end_i)
               nxt_state = ST_IDLE;
            else
               nxt_strobe = 4'h1 << kind_ff;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff     <= ST_IDLE;
         cnt_ff       <= {CNT_W{1'b0}};
         kind_ff      <= 2'h0;
         cmd_strobe_o <= 4'h0;
         acc_busy_o   <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         cmd_strobe_o <= nxt_strobe;
         acc_busy_o   <= (nxt_state != ST_IDLE);
         if (state_ff == ST_IDLE && acc_start_i)
            kind_ff <= acc_kind_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wiring flags are plain views of the stored bytes.
   assign video_port_a_wired_flag_o     = byte_c_ff[`CST_C_VIDEO_A_BIT];
   assign video_port_b_wired_flag_o     = byte_c_ff[`CST_C_VIDEO_B_BIT];
   assign speaker_wired_flag_o          = byte_c_ff[`CST_C_SPEAKER_BIT];
   assign status_indicator_wired_flag_o = byte_c_ff[`CST_C_INDICATOR_BIT];
   assign ext_clock_wired_flag_o        = byte_d_ff[`CST_D_EXT_CLK_BIT];
   assign supply_3v3_flag_o             = byte_b_ff[`CST_B_V33_BIT];

endmodule // cst_regs

// >>> test/cst_card_model.sv
// Purpose: Card-side model that ends each command phase.
// Assumes: Drives on the falling edge, like the rest of the bench.
// Notes:   hold_i sets how long the card keeps a command, so slow cards fit.
`timescale 1ns/1ns
module cst_card_model (
   // Clock, reset and strobes.
   input  wire       mclk_i,
   input  wire       rst_b_i,
   input  wire [3:0] strobe_i,
   input  wire [7:0] hold_i,
   // End of command.
   output wire       end_o
);
   reg [7:0] cnt_ff;
   reg       end_ff;
   assign end_o = end_ff;
   // Count active strobe cycles; end is high for one cycle, then drops whether or not the strobe has gone.
   always @(negedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_ff <= 8'h00;
         end_ff <= 1'b0;
      end else if (strobe_i != 4'h0 && !end_ff) begin
         end_ff <= (cnt_ff >= hold_i);
         cnt_ff <= cnt_ff + 8'h01;
      end else begin
         cnt_ff <= 8'h00;
         end_ff <= 1'b0;
      end
   end
endmodule // cst_card_model

// >>> test/cst_regs_checker.sv
// Purpose: Port-level assertions for the setup timer and register port.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   The setup length itself is judged by the bench, which knows S.
`timescale 1ns/1ns
module cst_regs_checker (
   // Clock and reset.
   input wire       mclk_i,
   input wire       rst_b_i,
   // Register port.
   input wire       reg_rd_i,
   input wire [7:0] reg_idx_i,
   input wire [7:0] reg_rdata_o,
   // Access port.
   input wire       acc_start_i,
   input wire [1:0] acc_kind_i,
   input wire       acc_end_i,
   input wire [3:0] cmd_strobe_o,
   input wire       acc_busy_o
);
   reg  [1:0] kind_ff;
   wire       take = acc_start_i && !acc_busy_o;
   wire       on   = (cmd_strobe_o != 4'h0);
   // Keep the kind of the taken access; starts while busy are refused.
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) kind_ff <= 2'h0;
      else if (take) kind_ff <= acc_kind_i;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   a_one_strobe: assert property ($onehot0(cmd_strobe_o))
      else $error("more than one strobe");
   a_setup_gap: assert property (take |=> !on && acc_busy_o)
      else $error("strobe without setup");
   a_strobe_kind: assert property (
      on |-> cmd_strobe_o == 4'h1 << kind_ff)
      else $error("wrong strobe");
   a_strobe_busy: assert property (on |-> acc_busy_o)
      else $error("strobe while idle");
   a_end_drops: assert property (
      on && acc_end_i |=> !on && !acc_busy_o)
      else $error("strobe not ended");
   a_strobe_holds: assert property (
      on && !acc_end_i |=> $stable(cmd_strobe_o))
      else $error("strobe changed");
   a_rise_busy: assert property ($rose(on) |-> $past(acc_busy_o))
      else $error("strobe rose early");
   a_unmapped_zero: assert property (
      reg_rd_i && reg_idx_i == 8'h55 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_stands: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
endmodule // cst_regs_checker
bind cst_regs cst_regs_checker cst_regs_checker_i (
   .mclk_i       (mclk_i),
   .rst_b_i      (rst_b_i),
   .reg_rd_i     (reg_rd_i),
   .reg_idx_i    (reg_idx_i),
   .reg_rdata_o  (reg_rdata_o),
   .acc_start_i  (acc_start_i),
   .acc_kind_i   (acc_kind_i),
   .acc_end_i    (acc_end_i),
   .cmd_strobe_o (cmd_strobe_o),
   .acc_busy_o   (acc_busy_o)
);

// >>> test/cst_regs_tb_top.sv
// Purpose: Self-checking bench for the setup timer and wiring registers.
// Assumes: Inputs change on the falling edge; the card model ends commands.
// Notes:   Large prescale codes use small multipliers to keep the run short.
`timescale 1ns/1ns
`include "cst_defs.vh"
module cst_regs_tb_top;
   reg        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, start = 1'b0;
   reg        win = 1'b0, mset = 1'b0;
   reg  [7:0] idx = 8'h00, wd = 8'h00, hold = 8'h00;
   reg  [3:0] vs = 4'h0;
   reg  [1:0] kind = 2'h0;
   wire [7:0] rdata;
   wire [3:0] strobe;
   wire [5:0] fl;
   wire       busy, aend;
   integer    bad_count = 0, total_checks = 0, cyc = 0, p;
   cst_regs cst_regs_i (.mclk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_idx_i(idx), .reg_wdata_i(wd), .reg_rdata_o(rdata),
      .vs_a_voltage_sense_one_i(vs[0]), .vs_a_voltage_sense_two_i(vs[1]),
      .vs_b_voltage_sense_one_i(vs[2]), .vs_b_voltage_sense_two_i(vs[3]),
      .acc_start_i(start), .acc_kind_i(kind), .acc_io_win_i(win),
      .acc_mem_set_i(mset), .acc_end_i(aend), .cmd_strobe_o(strobe),
      .acc_busy_o(busy), .video_port_a_wired_flag_o(fl[0]),
      .video_port_b_wired_flag_o(fl[1]), .speaker_wired_flag_o(fl[2]),
      .status_indicator_wired_flag_o(fl[3]), .ext_clock_wired_flag_o(fl[4]),
      .supply_3v3_flag_o(fl[5]));
   cst_card_model cst_card_model_i (.mclk_i(clk), .rst_b_i(rst_b),
      .strobe_i(strobe), .hold_i(hold), .end_o(aend));
   ////////////////////////////////////////////////////////////////////////
   // Clock and a cycle ceiling that cuts a hang short.
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         bad_count = bad_count + 1;
         wrap_up;
      end
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input logic ok, input string m);
      total_checks = total_checks + 1;
      if (ok !== 1'b1) begin
         bad_count = bad_count + 1;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Register port cycles: one strobe pulse, data seen one cycle later.
   task wrt(input [7:0] i, input [7:0] d);
      @(negedge clk); wr = 1'b1; idx = i; wd = d;
      @(negedge clk); wr = 1'b0;
   endtask
   task rdc(input [7:0] i, input [7:0] e, input string m);
      @(negedge clk); rd = 1'b1; idx = i;
      @(negedge clk); rd = 1'b0;
      chk(rdata === e, m);
   endtask
   task xwr(input [7:0] x, input [7:0] d);
      wrt(`CST_IDX_EXT_INDEX, x);
      wrt(`CST_IDX_EXT_DATA, d);
   endtask
   task xrd(input [7:0] x, input [7:0] e, input string m);
      wrt(`CST_IDX_EXT_INDEX, x);
      rdc(`CST_IDX_EXT_DATA, e, m);
   endtask
   // One access; a nonzero mid rewrites set 0 and retries start mid-setup.
   task acc(input [1:0] k, input w, input ms, input [7:0] mid,
            input integer s);
      integer n;
      @(negedge clk); start = 1'b1; kind = k; win = w; mset = ms;
      @(negedge clk); n = 0;
      if (mid !== 8'h00) begin
         wr = 1'b1; idx = `CST_IDX_SETUP_SET0; wd = mid;
         @(negedge clk); n = 1;
      end
      start = 1'b0; wr = 1'b0;
      while (strobe === 4'h0 && n < 9000) begin
         @(negedge clk); n = n + 1;
      end
      chk(n === s && strobe === 4'h1 << k, "setup length");
      while (busy !== 1'b0 && n < 9100) begin
         @(negedge clk); n = n + 1;
      end
      chk(busy === 1'b0, "access did not end");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      rdc(`CST_IDX_SETUP_SET0, 8'h01, "set0 reset");
      rdc(`CST_IDX_SETUP_SET1, 8'h01, "set1 reset");
      xrd(`CST_XIDX_BYTE_C, 8'h04, "byte c reset");
      xrd(`CST_XIDX_BYTE_D, 8'h00, "byte d reset");
      xrd(`CST_XIDX_BYTE_B, 8'h53, "byte b reset");
      rdc(8'h55, 8'h00, "unmapped read");
      chk(fl === 6'h24, "flags after reset");
   endtask
   // Firmware fills the wiring bytes before any card access.
   task t_wiring;
      xwr(`CST_XIDX_BYTE_C, 8'h19);
      xwr(`CST_XIDX_BYTE_D, 8'h40);
      xwr(`CST_XIDX_BYTE_B, 8'h52);
      chk(fl === 6'h1b, "wiring flags");
      xrd(`CST_XIDX_BYTE_C, 8'h19, "byte c readback");
      xwr(`CST_XIDX_BYTE_B, 8'h53);
      chk(fl === 6'h3b, "supply flag");
   endtask
   task t_sense;
      vs = 4'ha;
      xwr(`CST_XIDX_VSENSE, 8'hff);
      xrd(`CST_XIDX_VSENSE, 8'hfa, "sense a");
      vs = 4'h5;
      xrd(`CST_XIDX_VSENSE, 8'hf5, "sense b");
   endtask
   task t_prescale;
      for (p = 0; p < 4; p = p + 1) begin
         wrt(`CST_IDX_SETUP_SET0, {p[1:0], 6'h02});
         acc(p[1:0], 1'b0, 1'b0, 8'h00, (1 << (4 * p)) * 2 + 1);
      end
      wrt(`CST_IDX_SETUP_SET0, 8'h3f);
      acc(`CST_KIND_MEM_WR, 1'b0, 1'b0, 8'h00, 64);
      hold = 8'h05;
      wrt(`CST_IDX_SETUP_SET0, 8'hc0);
      acc(`CST_KIND_IO_WR, 1'b0, 1'b0, 8'h00, 1);
   endtask
   task t_sets;
      wrt(`CST_IDX_SETUP_SET0, 8'h03);
      wrt(`CST_IDX_SETUP_SET1, 8'h05);
      acc(`CST_KIND_MEM_RD, 1'b0, 1'b0, 8'h00, 4);
      acc(`CST_KIND_MEM_WR, 1'b0, 1'b1, 8'h00, 6);
      wrt(`CST_IDX_IO_WIN_CTRL, 8'h08);
      acc(`CST_KIND_IO_RD, 1'b0, 1'b0, 8'h00, 6);
      acc(`CST_KIND_IO_WR, 1'b1, 1'b0, 8'h00, 4);
      wrt(`CST_IDX_IO_WIN_CTRL, 8'h80);
      acc(`CST_KIND_IO_WR, 1'b1, 1'b0, 8'h00, 6);
      acc(`CST_KIND_IO_RD, 1'b0, 1'b0, 8'h00, 4);
   endtask
   // A rewrite during setup leaves the running access alone.
   task t_mid;
      hold = 8'h02;
      wrt(`CST_IDX_SETUP_SET0, 8'h0a);
      acc(`CST_KIND_MEM_RD, 1'b0, 1'b0, 8'h02, 11);
      acc(`CST_KIND_MEM_WR, 1'b0, 1'b0, 8'h00, 3);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk); rst_b = 1'b1;
      t_reset;
      t_wiring;
      t_sense;
      t_prescale;
      t_sets;
      t_mid;
      wrap_up;
   end
endmodule // cst_regs_tb_top
